// *** quad_strobe_pkg.sv ***
// Package for the quad strobe port: register offsets, field layout, reset values.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package quad_strobe_pkg;

  // Printed offsets are not all multiples of four, so they are kept as indices
  localparam logic [7:0] IDX_STROBE_CTRL_LOW_PINS = 8'h92;
  localparam logic [7:0] IDX_STROBE_CTRL_HIGH_PINS = 8'h93;
  // Chosen indices for registers that have no printed offset
  localparam logic [7:0] IDX_PIN_BASE_ADDR_LOW = 8'h94;
  localparam logic [7:0] IDX_PIN_BASE_ADDR_HIGH = 8'h98;
  localparam logic [7:0] IDX_GPIO_OUT = 8'ha5;
  localparam logic [7:0] IDX_GPIO_DIR = 8'ha6;

  localparam int ADDR_W = 12;
  localparam int MODE_LSB = 2;
  localparam int CMP_LSB = 0;
  localparam int FIELD_W = 4;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BASE_RESET = 8'h00;
  localparam logic [3:0] GPIO_OUT_RESET = 4'hf;
  localparam logic [3:0] GPIO_DIR_RESET = 4'h0;

  localparam logic [1:0] MODE_GPIO = 2'h0;
  localparam logic [1:0] MODE_READ = 2'h1;
  localparam logic [1:0] MODE_WRITE = 2'h2;
  localparam logic [1:0] MODE_BOTH = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** quad_strobe_port.sv ***
// Four-pin multipurpose port: general I/O or address-decoded chip-select strobes.
// Assumes the external data bus strobes arrive on pins and are synchronised here;
// the address is stable while a strobe is low.
//
// Overview of operation
// [R01] Mode 0 makes the pin a plain bidirectional general-purpose I/O bit.
// [R02] Mode 1 drives a read strobe, active on external reads inside the range.
// [R03] Mode 2 drives a write strobe, active on external writes inside the range.
// [R04] Mode 3 drives a strobe on external reads or writes inside the range.
// [R05] Range comes from the pin's base high and low bytes plus its compare width.
// [R06] Compare width 0 matches all 16 address bits against the base.
// [R07] Compare width 1 matches address bits 15 to 1, ignoring bit 0.
// [R08] Compare width 2 matches address bits 15 to 2, ignoring two low bits.
// [R09] Compare width 3 matches the upper eight address bits only.
// [R10] Low-pins control: pin 1 mode 7:6, compare 5:4; pin 0 mode 3:2, compare 1:0.
// [R11] High-pins control: pin 3 mode 7:6, compare 5:4; pin 2 mode 3:2, compare 1:0.
// [R12] After reset all four pins are general-purpose I/O.
// [R13] Each pin's 16-bit base is a high byte register and a low byte register.
// [R14] Strobe output follows the matching external read or write strobe.
// [R15] Strobes stay inactive when no external data access is in progress.
`timescale 1ns/1ps

module quad_strobe_port #(
  parameter int PINS = 4
) (
  input wire logic clk_i, // 100 MHz core clock
  input wire logic rst_n_i, // Asynchronous reset, active low
  input wire logic [quad_strobe_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [quad_strobe_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [15:0] ext_addr_i, // External data address
  input wire logic ext_rd_n_i, // External read strobe, active low
  input wire logic ext_wr_n_i, // External write strobe, active low
  input wire logic [PINS-1:0] pin_i, // Pin levels
  output logic [PINS-1:0] pin_o, // Pin output values
  output logic [PINS-1:0] pin_oe_n_o // Pin output enables, low drives
);

  typedef struct packed {
    logic [PINS-1:0][7:0] base_lo;
    logic [PINS-1:0][7:0] base_hi;
    logic [7:0] ctrl_lo;
    logic [7:0] ctrl_hi;
    logic [PINS-1:0] gpio_out;
    logic [PINS-1:0] gpio_dir;
    logic [1:0] rd_sync_n;
    logic [1:0] wr_sync_n;
    logic [1:0][15:0] addr_sync;
    logic [1:0][PINS-1:0] pin_sync;
    logic [PINS-1:0] strobe_n;
    logic aw_held;
    logic w_held;
    logic [quad_strobe_pkg::ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_t;

  state_t st;
  state_t next_st;

  // Byte address of a register index
  function automatic logic [quad_strobe_pkg::ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    reg_addr = quad_strobe_pkg::ADDR_W'({idx, 2'b00});
  endfunction

  // Masked 16-bit compare by compare-width code
  function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] b,
                                    input logic [1:0] cw);
    case (cw)
      2'h0: addr_hit = (a == b); // [R06]
      2'h1: addr_hit = (a[15:1] == b[15:1]); // [R07]
      2'h2: addr_hit = (a[15:2] == b[15:2]); // [R08]
      2'h3: addr_hit = (a[15:8] == b[15:8]); // [R09]
      default: addr_hit = 1'b0;
    endcase
  endfunction

  logic [PINS-1:0][1:0] pin_mode;
  logic [PINS-1:0][1:0] pin_cmp;
  logic [PINS-1:0] pin_strobe_n;
  logic rd_act;
  logic wr_act;

  // Second sync stage only is read by logic
  assign rd_act = ~st.rd_sync_n[1];
  assign wr_act = ~st.wr_sync_n[1];

  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      logic [7:0] ctrl;
      logic [15:0] base;
      logic hit;
      // Even pins use the low nibble, odd pins the high nibble
      assign ctrl = (g < 2) ? st.ctrl_lo : st.ctrl_hi; // [R10] [R11]
      assign pin_mode[g] = ctrl[(g%2)*quad_strobe_pkg::FIELD_W+quad_strobe_pkg::MODE_LSB +: 2];
      assign pin_cmp[g] = ctrl[(g%2)*quad_strobe_pkg::FIELD_W+quad_strobe_pkg::CMP_LSB +: 2];
      assign base = {st.base_hi[g], st.base_lo[g]}; // [R13] [R05]
      assign hit = addr_hit(st.addr_sync[1], base, pin_cmp[g]);
      // One continuous driver per bit keeps the strobe vector single-sourced
      assign pin_strobe_n[g] =
        (pin_mode[g] == quad_strobe_pkg::MODE_READ) ? ~(rd_act & hit) : // [R02] [R14]
        (pin_mode[g] == quad_strobe_pkg::MODE_WRITE) ? ~(wr_act & hit) : // [R03] [R14]
        (pin_mode[g] == quad_strobe_pkg::MODE_BOTH) ? ~((rd_act | wr_act) & hit) : // [R04]
        1'b1; // [R15]
      // Strobe modes always drive; GPIO drives only where the direction bit is set
      assign pin_o[g] = (pin_mode[g] == quad_strobe_pkg::MODE_GPIO) ?
                        st.gpio_out[g] : st.strobe_n[g]; // [R01]
      assign pin_oe_n_o[g] = (pin_mode[g] == quad_strobe_pkg::MODE_GPIO) ?
                             ~st.gpio_dir[g] : 1'b0;
    end
  endgenerate

  logic aw_go;
  logic w_go;
  logic wr_fire;
  logic ar_go;
  logic [31:0] rd_word;
  logic rd_ok;

  assign s_axi_awready = ~st.aw_held & ~st.bvalid;
  assign s_axi_wready = ~st.w_held & ~st.bvalid;
  assign s_axi_arready = ~st.rvalid;
  assign aw_go = s_axi_awvalid & s_axi_awready;
  assign w_go = s_axi_wvalid & s_axi_wready;
  assign ar_go = s_axi_arvalid & s_axi_arready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = st.rdata;

  // Read mux; GPIO data shows synchronised pin levels, as a port read would
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_axi_araddr == reg_addr(quad_strobe_pkg::IDX_STROBE_CTRL_LOW_PINS)) begin
      rd_word = {24'h00_0000, st.ctrl_lo};
    end else if (s_axi_araddr == reg_addr(quad_strobe_pkg::IDX_STROBE_CTRL_HIGH_PINS)) begin
      rd_word = {24'h00_0000, st.ctrl_hi};
    end else if (s_axi_araddr == reg_addr(quad_strobe_pkg::IDX_GPIO_OUT)) begin
      rd_word = 32'(st.pin_sync[1]);
    end else if (s_axi_araddr == reg_addr(quad_strobe_pkg::IDX_GPIO_DIR)) begin
      rd_word = 32'(st.gpio_dir);
    end else begin
      rd_ok = 1'b0;
      for (int i = 0; i < PINS; i++) begin
        if (s_axi_araddr == reg_addr(8'(quad_strobe_pkg::IDX_PIN_BASE_ADDR_LOW + i))) begin
          rd_word = {24'h00_0000, st.base_lo[i]};
          rd_ok = 1'b1;
        end
        if (s_axi_araddr == reg_addr(8'(quad_strobe_pkg::IDX_PIN_BASE_ADDR_HIGH + i))) begin
          rd_word = {24'h00_0000, st.base_hi[i]};
          rd_ok = 1'b1;
        end
      end
    end
  end

  always_comb begin
    logic [quad_strobe_pkg::ADDR_W-1:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic hit_w;
    next_st = st;
    wa = aw_go ? s_axi_awaddr : st.aw_addr;
    wd = w_go ? s_axi_wdata : st.w_data;
    ws = w_go ? s_axi_wstrb : st.w_strb;
    hit_w = 1'b1;
    wr_fire = (st.aw_held | aw_go) & (st.w_held | w_go);
    next_st.rd_sync_n = {st.rd_sync_n[0], ext_rd_n_i};
    next_st.wr_sync_n = {st.wr_sync_n[0], ext_wr_n_i};
    next_st.addr_sync = {st.addr_sync[0], ext_addr_i};
    next_st.pin_sync = {st.pin_sync[0], pin_i};
    next_st.strobe_n = pin_strobe_n;
    if (aw_go) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (w_go) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      // Only byte lane 0 carries register data
      if (wa == reg_addr(quad_strobe_pkg::IDX_STROBE_CTRL_LOW_PINS)) begin
        if (ws[0]) next_st.ctrl_lo = wd[7:0]; // [R10]
      end else if (wa == reg_addr(quad_strobe_pkg::IDX_STROBE_CTRL_HIGH_PINS)) begin
        if (ws[0]) next_st.ctrl_hi = wd[7:0]; // [R11]
      end else if (wa == reg_addr(quad_strobe_pkg::IDX_GPIO_OUT)) begin
        if (ws[0]) next_st.gpio_out = wd[PINS-1:0];
      end else if (wa == reg_addr(quad_strobe_pkg::IDX_GPIO_DIR)) begin
        if (ws[0]) next_st.gpio_dir = wd[PINS-1:0];
      end else begin
        hit_w = 1'b0;
        for (int i = 0; i < PINS; i++) begin
          if (wa == reg_addr(8'(quad_strobe_pkg::IDX_PIN_BASE_ADDR_LOW + i))) begin
            hit_w = 1'b1;
            if (ws[0]) next_st.base_lo[i] = wd[7:0]; // [R13]
          end
          if (wa == reg_addr(8'(quad_strobe_pkg::IDX_PIN_BASE_ADDR_HIGH + i))) begin
            hit_w = 1'b1;
            if (ws[0]) next_st.base_hi[i] = wd[7:0]; // [R13]
          end
        end
      end
      next_st.bresp = hit_w ? quad_strobe_pkg::RESP_OKAY : quad_strobe_pkg::RESP_SLVERR;
    end else if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (ar_go) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_word;
      next_st.rresp = rd_ok ? quad_strobe_pkg::RESP_OKAY : quad_strobe_pkg::RESP_SLVERR;
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
      st.ctrl_lo <= quad_strobe_pkg::CTRL_RESET; // [R12]
      st.ctrl_hi <= quad_strobe_pkg::CTRL_RESET; // [R12]
      st.base_lo <= '0;
      st.base_hi <= '0;
      st.gpio_out <= quad_strobe_pkg::GPIO_OUT_RESET;
      st.gpio_dir <= quad_strobe_pkg::GPIO_DIR_RESET;
      st.rd_sync_n <= 2'h3;
      st.wr_sync_n <= 2'h3;
      st.strobe_n <= '1;
    end else begin
      st <= next_st;
    end
  end

endmodule // quad_strobe_port

// *** quad_strobe_port_checker.sv ***
// Checker for the quad strobe port: bus answers, reset state, strobe timing.
// Bound to every quad_strobe_port; watches its ports only.
`timescale 1ns/1ps
module quad_strobe_port_checker #(parameter int PINS = 4) (
  input wire logic clk_i, rst_n_i, // Clock, reset
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, // Write request
  input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, // Answers
  input wire logic s_axi_rvalid, s_axi_rready, ext_rd_n_i, ext_wr_n_i, // Read, bus strobes
  input wire logic [1:0] s_axi_bresp, // Write response
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic [PINS-1:0] pin_o, pin_oe_n_o // Pins
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Cycles since a register write; a mode change may move a pin by itself
  logic [2:0] quiet;
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i) quiet <= 3'h0;
    else if (s_axi_awvalid && s_axi_awready || s_axi_wvalid && s_axi_wready) quiet <= 3'h0;
    else if (quiet != 3'h7) quiet <= quiet + 3'h1;
  property p_reset; $rose(rst_n_i) |-> pin_oe_n_o == '1 && pin_o == '1; endproperty
  a_reset: assert property (p_reset) else $error("pins not inputs after reset");
  property p_idle;
    (ext_rd_n_i && ext_wr_n_i)[*4] ##0 quiet > 3 |-> ($past(pin_o) & ~pin_o) == '0;
  endproperty
  a_idle: assert property (p_idle) else $error("strobe fell with bus idle");
  property p_lag;
    quiet > 3 && ($past(pin_o) & ~pin_o) != '0 |-> !$past(ext_rd_n_i, 3) || !$past(ext_wr_n_i, 3);
  endproperty
  a_lag: assert property (p_lag) else $error("strobe fell off its bus cycle");
  property p_rel;
    quiet > 3 && (~$past(pin_o) & pin_o) != '0 |-> $past(ext_rd_n_i, 3) && $past(ext_wr_n_i, 3);
  endproperty
  a_rel: assert property (p_rel) else $error("strobe rose off its bus cycle");
  property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=>
    s_axi_bvalid && !s_axi_awready; endproperty
  a_wr: assert property (p_wr) else $error("write not answered");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
  c_cs: cover property (quiet > 3 && ($past(pin_o) & ~pin_o) != '0);
endmodule // quad_strobe_port_checker
bind quad_strobe_port quad_strobe_port_checker #(.PINS(PINS)) u_chk (.*);

// *** strobe_periph.sv ***
// Peripheral side of the port: far-side pin levels and a record of selects.
// Undriven pins read the far-side level given on drv_i; driven pins read the port value.
`timescale 1ns/1ps
module strobe_periph (
  input wire logic clk_i, // Core clock
  input wire logic clr_i, // Clears the select record
  input wire logic [3:0] out_i, // Port drive values
  input wire logic [3:0] oe_n_i, // Port enables, low drives
  input wire logic [3:0] drv_i, // Far-side level of undriven pins
  output logic [3:0] pin_o, // Resolved pin levels
  output logic [3:0] seen_o // Pins that selected since clear
);
  assign pin_o = ~oe_n_i & out_i | oe_n_i & drv_i;
  always @(posedge clk_i) seen_o <= clr_i ? 4'h0 : seen_o | ~oe_n_i & ~out_i;
endmodule // strobe_periph

// *** tb_quad_strobe_port.sv ***
// Bench for the quad strobe port: registers, general I/O and decoded strobes.
// Drives the design and a peripheral model; a monitor checks against a queue.
`timescale 1ns/1ps
module tb_quad_strobe_port;
  localparam logic [7:0] CL = quad_strobe_pkg::IDX_STROBE_CTRL_LOW_PINS;
  localparam logic [7:0] CH = quad_strobe_pkg::IDX_STROBE_CTRL_HIGH_PINS;
  logic clk_i = 0, rst_n_i = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, ext_rd_n_i = 1, ext_wr_n_i = 1, acc_end = 1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0, pin_i, pin_o, pin_oe_n_o, seen, drv = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] ext_addr_i = 0;
  logic [33:0] exp_q[$];
  logic [7:0] rnd = 8'h4e;
  logic [1:0] md[4] = '{2'h2, 2'h1, 2'h3, 2'h3};
  logic [1:0] cw[4] = '{2'h2, 2'h0, 2'h1, 2'h3};
  logic [15:0] bs[4] = '{16'h1234, 16'h1235, 16'h2000, 16'h4056};
  int fails = 0, num_checks = 0;
  always #5 clk_i = ~clk_i;
  quad_strobe_port dut (.*);
  strobe_periph u_per (.clk_i(clk_i), .clr_i(acc_end), .out_i(pin_o), .oe_n_i(pin_oe_n_o),
    .drv_i(drv), .pin_o(pin_i), .seen_o(seen));
  function automatic logic [3:0] hits(input logic [15:0] a, input logic rd);
    logic [15:0] m;
    hits = 4'h0;
    for (int i = 0; i < 4; i++) begin
      m = cw[i] == 2'h0 ? 16'hffff : cw[i] == 2'h1 ? 16'hfffe : cw[i] == 2'h2 ? 16'hfffc : 16'hff00;
      hits[i] = ((a ^ bs[i]) & m) == 16'h0 && (md[i] == 2'h3 || md[i] == {~rd, rd});
    end
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string nm, input logic [33:0] sv, ev);
    num_checks++;
    if (sv !== ev) begin
      $display("Error %s expected %h seen %h", nm, ev, sv);
      fails++;
    end
  endtask
  task automatic tick(inout int n);
    @(posedge clk_i);
    n++;
    if (n > 200) begin
      fails++;
      close_out();
    end
  endtask
  always @(posedge clk_i) begin
    if (s_axi_rvalid && s_axi_rready) check("read", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    if (s_axi_bvalid && s_axi_bready) check("write", {s_axi_bresp, 32'h0}, exp_q.pop_front());
    if (acc_end && rst_n_i) check("selects", {30'h0, seen}, exp_q.pop_front());
  end
  // Ready is held back two cycles so the slave must hold its answer
  task automatic bus(input logic w, input logic [7:0] idx, d, input logic [33:0] ex);
    int n = 0;
    exp_q.push_back(ex);
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= {3'h0, d != 8'hee};
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    do begin
      tick(n);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n == 2) s_axi_bready <= w;
      if (n == 2) s_axi_rready <= !w;
    end while (!(s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready));
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask
  task automatic ext_acc(input logic [15:0] a, input logic rd);
    exp_q.push_back({30'h0, hits(a, rd)});
    ext_addr_i <= a;
    repeat (2) @(posedge clk_i);
    ext_rd_n_i <= !rd;
    ext_wr_n_i <= rd;
    repeat (4) @(posedge clk_i);
    ext_rd_n_i <= 1'b1;
    ext_wr_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    acc_end <= 1'b1;
    @(posedge clk_i);
    acc_end <= 1'b0;
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    acc_end <= 1'b0;
    rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
    drv <= {rnd[1:0], 2'h0};
    @(posedge clk_i);
    bus(0, CL, 8'h0, 34'h0);
    bus(0, CH, 8'h0, 34'h0);
    bus(0, 8'h00, 8'h0, {quad_strobe_pkg::RESP_SLVERR, 32'h0});
    bus(1, 8'h00, 8'hff, {quad_strobe_pkg::RESP_SLVERR, 32'h0});
    bus(1, quad_strobe_pkg::IDX_GPIO_DIR, 8'h03, 34'h0);
    bus(1, quad_strobe_pkg::IDX_GPIO_DIR, 8'hee, 34'h0);
    bus(1, quad_strobe_pkg::IDX_GPIO_OUT, 8'h03, 34'h0);
    bus(0, quad_strobe_pkg::IDX_GPIO_OUT, 8'h0, {30'h0, drv[3:2], 2'h3});
    for (int i = 0; i < 4; i++) begin
      bus(1, quad_strobe_pkg::IDX_PIN_BASE_ADDR_LOW + 8'(i), bs[i][7:0], 34'h0);
      bus(1, quad_strobe_pkg::IDX_PIN_BASE_ADDR_HIGH + 8'(i), bs[i][15:8], 34'h0);
    end
    bus(0, quad_strobe_pkg::IDX_PIN_BASE_ADDR_HIGH + 8'h3, 8'h0, 34'h40);
    bus(1, CL, {md[1], cw[1], md[0], cw[0]}, 34'h0);
    bus(1, CH, {md[3], cw[3], md[2], cw[2]}, 34'h0);
    bus(0, CH, 8'h0, {26'h0, md[3], cw[3], md[2], cw[2]});
    for (int k = 0; k < 40; k++) begin
      rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
      ext_acc(bs[rnd[7:6]] ^ {7'h0, rnd[5], 5'h0, rnd[2:0]}, rnd[3]);
    end
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    bus(0, CL, 8'h0, 34'h0);
    close_out();
  end
endmodule // tb_quad_strobe_port
